//--- logic/sp_cfg_pkg.sv
// serial port settings: register map, field layouts, codes, defaults
// assumes a 32-bit word register port and a single system clock
`default_nettype none
package sp_cfg_pkg;
    // register byte offsets, one aligned word each
    localparam logic [7:0] A_PORT = 8'h00;
    localparam logic [7:0] A_FLOW = 8'h04;
    localparam logic [7:0] A_DLY = 8'h08;
    localparam logic [7:0] A_GAP = 8'h0C;
    localparam logic [7:0] A_TXCTL = 8'h10;
    localparam logic [7:0] A_STAT = 8'h14;
    localparam logic [7:0] A_ACTP = 8'h18;
    localparam logic [7:0] A_ACTF = 8'h1C;
    localparam logic [31:0] RD_NONE = 32'h0000_0000;
    // selector codes
    localparam logic [3:0] PROTO_PTP = 4'h0;
    localparam logic [3:0] FLOW_NONE = 4'h1;
    localparam logic [3:0] FLOW_SW = 4'h2;
    localparam logic [3:0] FLOW_HW_ON = 4'h3;
    localparam logic [3:0] FLOW_HW_SW = 4'h4;
    localparam logic [3:0] PAR_NONE = 4'h1;
    localparam logic [3:0] PAR_EVEN = 4'h2;
    localparam logic [3:0] PAR_ODD = 4'h3;
    localparam logic [3:0] PAR_MARK = 4'h4;
    localparam logic [3:0] PAR_MAX = 4'h5;
    localparam logic [3:0] LEN_7 = 4'h2;
    localparam logic [3:0] STOP_2 = 4'h2;
    localparam logic [3:0] SEL2_MAX = 4'h2;
    localparam logic [3:0] BAUD_MAX = 4'hB;
    localparam logic [3:0] FLOW_MAX = 4'h4;
    // condition codes
    localparam logic [15:0] ST_OK = 16'h0000;
    localparam logic [15:0] ST_PROTO = 16'h80A0;
    localparam logic [15:0] ST_BAUD = 16'h80A1;
    localparam logic [15:0] ST_PAR = 16'h80A2;
    localparam logic [15:0] ST_LEN = 16'h80A3;
    localparam logic [15:0] ST_STOP = 16'h80A4;
    localparam logic [15:0] ST_FLOW = 16'h80A5;
    localparam logic [15:0] ST_WAIT0 = 16'h80A6;
    localparam logic [15:0] ST_CHARS = 16'h80A7;
    localparam logic [15:0] ST_TXINT = 16'h80B0;
    localparam logic [15:0] ST_BRKLEN = 16'h80B1;
    localparam logic [15:0] ST_IDLELEN = 16'h80B2;
    // timing
    localparam int unsigned CLK_HZ_DEF = 250_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned GAP_MAX_S = 8;
    typedef struct packed {
        logic [3:0] protocol;
        logic [3:0] flow_control_select;
        logic [3:0] stop_bit_select;
        logic [3:0] char_length_select;
        logic [3:0] parity;
        logic [3:0] baud;
    } port_mode_t;
    typedef struct packed {
        logic [15:0] flow_wait_ms;
        logic [7:0] pause_char_code;
        logic [7:0] resume_char_code;
    } flow_cfg_t;
    typedef struct packed {
        logic [15:0] handshake_trail_delay;
        logic [15:0] handshake_lead_delay;
    } dly_cfg_t;
    typedef struct packed {
        logic [15:0] pre_message_idle_bits;
        logic [15:0] break_bits;
    } gap_cfg_t;
    typedef enum logic [2:0] {
        ST_IDLE, ST_LEAD, ST_CTS, ST_GAP, ST_BRK, ST_DATA, ST_TRAIL
    } tx_state_t;
    // static defaults: ptp, 9600 8N1, no flow control
    localparam port_mode_t DEF_PORT = '{4'h0, 4'h1, 4'h1, 4'h1, 4'h1, 4'h6};
    localparam flow_cfg_t DEF_FLOW = '{16'd2000, 8'h13, 8'h11};
    localparam dly_cfg_t DEF_DLY = '{16'h0000, 16'h0000};
    localparam gap_cfg_t DEF_GAP = '{16'd12, 16'd12};
    // baud code to bits per second, zero for an unknown code
    function automatic int unsigned baud_rate(input logic [3:0] c);
        case (c)
            4'h1: return 300;
            4'h2: return 600;
            4'h3: return 1200;
            4'h4: return 2400;
            4'h5: return 4800;
            4'h6: return 9600;
            4'h7: return 19200;
            4'h8: return 38400;
            4'h9: return 57600;
            4'hA: return 76800;
            4'hB: return 115200;
            default: return 0;
        endcase
    endfunction
endpackage
`default_nettype wire

//--- logic/serial_port_tx_config.sv
// serial port settings check and transmit framing (lead, gap, break, trail)
// assumes synchronous inputs, one clock, a word register port
// Operation
// R1: flow select 1 none, 2 pause/resume chars, 3 handshake always on, 4 switched.
// R2: resume character recognised from configured code, only under flow control.
// R3: pause character recognised from configured code, only under flow control.
// R4: after pause, wait at most flow_wait_ms for resume, then carry on.
// R5: under handshake, wait at most flow_wait_ms for cts after raising rts.
// R6: done pulses one cycle on success, error one cycle on failure.
// R7: a change starts only on a rising edge of its request input.
// R8: port setup reports 80A0..80A5 for bad protocol, baud, parity, length, stop, flow.
// R9: port setup reports 80A6 when wait is zero with flow control on.
// R10: port setup reports 80A7 for equal pause and resume codes; the code checks this only when flow select is not 1.
// R11: transmit setup discards every queued message.
// R12: under handshake, wait lead delay after rts before data; zero skips.
// R13: under handshake, hold rts trail delay after data; zero skips.
// R14: break of configured bit times starts each message; zero skips.
// R15: line idle for configured bit times before each message; zero skips.
// R16: transmit setup reports 80B1 when break exceeds eight seconds.
// R17: transmit setup reports 80B2 when idle gap exceeds eight seconds.
// R18: transmit setup reports 80B0 when a transmit interrupt is requested.
// R19: run-time settings volatile; defaults reload on stop mode and reset.
// R20: baud codes 1..11 give 300 up to 115200 baud.
// R21: parity 1 none, 2 even, 3 odd, 4 mark, 5 space.
// R22: length 1 eight, 2 seven bits; stop 1 one, 2 two bits.
// R23: break drives space, idle gap drives mark.
// R24: success leaves status zero; a rejected request keeps old settings.
//
// The address-and-strobe port and the register offsets were left to the implementer.
`default_nettype none
module serial_port_tx_config
    import sp_cfg_pkg::*;
#(
    parameter int unsigned CLK_HZ = CLK_HZ_DEF
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic port_cfg_req,
    input wire logic send_cfg_req,
    input wire logic run_mode,
    output logic cfg_done,
    output logic cfg_error,
    output logic [15:0] cfg_status,
    input wire logic msg_req,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    output logic tx_ready,
    output logic tx_flush,
    output logic tx_busy,
    output logic tx_line,
    output logic rts,
    input wire logic cts,
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_char,
    output logic flow_timeout
);
    localparam int unsigned MS_CYC = CLK_HZ / MS_PER_S;
    localparam logic [63:0] GAP_LIM = 64'(CLK_HZ) * 64'(GAP_MAX_S);

    // code lies in 1..max
    function automatic logic in_range(input logic [3:0] v,
                                      input logic [3:0] max);
        return (v != 4'h0) && (v <= max);
    endfunction

    // clock cycles per bit for a baud code
    function automatic logic [31:0] bit_cycles(input logic [3:0] c);
        int unsigned r;
        r = baud_rate(c);
        return (r == 0) ? 32'h0000_0001 : 32'(CLK_HZ / r);
    endfunction

    // one character frame, lsb first, ones beyond the stop bits
    function automatic logic [11:0] make_frame(input logic [7:0] d,
                                               input port_mode_t p);
        logic [11:0] f;
        logic [7:0] dd;
        logic pb;
        f = 12'hFFF;
        dd = (p.char_length_select == LEN_7) ? {1'b0, d[6:0]} : d;
        case (p.parity)
            PAR_EVEN: pb = ^dd;
            PAR_ODD: pb = ~^dd;
            PAR_MARK: pb = 1'b1;
            default: pb = 1'b0;
        endcase
        if (p.char_length_select == LEN_7) begin
            f[7:1] = dd[6:0];
            if (p.parity != PAR_NONE) f[8] = pb;
        end else begin
            f[8:1] = dd;
            if (p.parity != PAR_NONE) f[9] = pb;
        end
        f[0] = 1'b0;
        return f;
    endfunction

    logic [1:0] rs_ff;
    wire logic rst_s_n = rs_ff[1];
    port_mode_t stg_port_ff, act_port_ff;
    flow_cfg_t stg_flow_ff, act_flow_ff;
    dly_cfg_t stg_dly_ff, act_dly_ff;
    gap_cfg_t stg_gap_ff, act_gap_ff;
    logic txint_ff, preq_d_ff, sreq_d_ff, run_d_ff, pend_ff;
    logic done_ff, error_ff, flush_ff, ready_ff, line_ff, rts_ff;
    logic busy_ff, to_ff, paused_ff, last_ff;
    logic [15:0] status_ff, cnt_ff, p_cnt_ff;
    logic [31:0] rdata_ff, ms_div_ff, bit_div_ff;
    logic [11:0] ser_ff;
    logic [3:0] left_ff;
    tx_state_t st_ff, nxt_st;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_s_n);

    // reset release through two flops
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) rs_ff <= 2'b00;
        else rs_ff <= {rs_ff[0], 1'b1};
    end

    // request edges and stop-mode edge
    wire logic port_rise = port_cfg_req && !preq_d_ff; // [R7]
    wire logic send_rise = send_cfg_req && !sreq_d_ff && !port_rise; // [R7]
    wire logic stop_edge = run_d_ff && !run_mode; // [R19]
    wire logic hw_fc = (act_port_ff.flow_control_select == FLOW_HW_ON) ||
                       (act_port_ff.flow_control_select == FLOW_HW_SW);
    wire logic sw_fc = act_port_ff.flow_control_select == FLOW_SW; // [R1]
    wire logic [15:0] wait_ms = act_flow_ff.flow_wait_ms;

    // port setup check, first failure wins
    wire logic stg_fc = stg_port_ff.flow_control_select != FLOW_NONE;
    wire logic [15:0] port_code =
        (stg_port_ff.protocol != PROTO_PTP) ? ST_PROTO : // [R8]
        !in_range(stg_port_ff.baud, BAUD_MAX) ? ST_BAUD : // [R20]
        !in_range(stg_port_ff.parity, PAR_MAX) ? ST_PAR : // [R21]
        !in_range(stg_port_ff.char_length_select, SEL2_MAX) ? ST_LEN :
        !in_range(stg_port_ff.stop_bit_select, SEL2_MAX) ? ST_STOP : // [R22]
        !in_range(stg_port_ff.flow_control_select, FLOW_MAX) ? ST_FLOW :
        (stg_fc && stg_flow_ff.flow_wait_ms == 16'h0000) ? ST_WAIT0 : // [R9]
        (stg_fc && stg_flow_ff.pause_char_code ==
         stg_flow_ff.resume_char_code) ? ST_CHARS : ST_OK; // [R10]

    // transmit setup check against the active baud
    wire logic [31:0] bit_cyc = bit_cycles(act_port_ff.baud);
    wire logic [63:0] brk_cyc = 64'(stg_gap_ff.break_bits) * 64'(bit_cyc);
    wire logic [63:0] idl_cyc =
        64'(stg_gap_ff.pre_message_idle_bits) * 64'(bit_cyc);
    wire logic [15:0] send_code =
        txint_ff ? ST_TXINT : // [R18]
        (brk_cyc > GAP_LIM) ? ST_BRKLEN : // [R16]
        (idl_cyc > GAP_LIM) ? ST_IDLELEN : ST_OK; // [R17]
    wire logic [15:0] req_code = port_rise ? port_code : send_code;
    wire logic any_rise = port_rise || send_rise;

    // result pulses and status word
    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            done_ff <= 1'b0;
            error_ff <= 1'b0;
            status_ff <= ST_OK;
        end else begin
            done_ff <= any_rise && req_code == ST_OK; // [R6]
            error_ff <= any_rise && req_code != ST_OK; // [R6]
            if (any_rise) status_ff <= req_code; // [R24]
        end
    end

    // active settings: defaults on reset and stop, staging on success
    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            act_port_ff <= DEF_PORT;
            act_flow_ff <= DEF_FLOW;
            act_dly_ff <= DEF_DLY;
            act_gap_ff <= DEF_GAP;
        end else if (stop_edge) begin // [R19]
            act_port_ff <= DEF_PORT;
            act_flow_ff <= DEF_FLOW;
            act_dly_ff <= DEF_DLY;
            act_gap_ff <= DEF_GAP;
        end else if (port_rise && port_code == ST_OK) begin // [R24]
            act_port_ff <= stg_port_ff;
            act_flow_ff <= stg_flow_ff;
        end else if (send_rise && send_code == ST_OK) begin // [R24]
            act_dly_ff <= stg_dly_ff;
            act_gap_ff <= stg_gap_ff;
        end
    end

    // register writes into staging
    wire logic wr_port = reg_wr && reg_addr == A_PORT;
    wire logic wr_flow = reg_wr && reg_addr == A_FLOW;
    wire logic wr_dly = reg_wr && reg_addr == A_DLY;
    wire logic wr_gap = reg_wr && reg_addr == A_GAP;
    wire logic wr_txc = reg_wr && reg_addr == A_TXCTL;
    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            stg_port_ff <= DEF_PORT;
            stg_flow_ff <= DEF_FLOW;
            stg_dly_ff <= DEF_DLY;
            stg_gap_ff <= DEF_GAP;
            txint_ff <= 1'b0;
        end else begin
            if (wr_port) stg_port_ff <= reg_wdata[23:0];
            if (wr_flow) stg_flow_ff <= reg_wdata;
            if (wr_dly) stg_dly_ff <= reg_wdata;
            if (wr_gap) stg_gap_ff <= reg_wdata;
            if (wr_txc) txint_ff <= reg_wdata[0];
        end
    end

    // read mux, data valid only in the cycle after the strobe
    wire logic [31:0] stat_word = {13'h0000, busy_ff, paused_ff, rts_ff,
                                   status_ff};
    wire logic [31:0] rd_mux =
        (reg_addr == A_PORT) ? {8'h00, stg_port_ff} :
        (reg_addr == A_FLOW) ? stg_flow_ff :
        (reg_addr == A_DLY) ? stg_dly_ff :
        (reg_addr == A_GAP) ? stg_gap_ff :
        (reg_addr == A_TXCTL) ? {31'h0000_0000, txint_ff} :
        (reg_addr == A_STAT) ? stat_word :
        (reg_addr == A_ACTP) ? {8'h00, act_port_ff} :
        (reg_addr == A_ACTF) ? act_flow_ff : RD_NONE;

    // edge history, pending message, read data
    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            preq_d_ff <= 1'b0;
            sreq_d_ff <= 1'b0;
            run_d_ff <= 1'b0;
            pend_ff <= 1'b0;
            flush_ff <= 1'b0;
            rdata_ff <= RD_NONE;
        end else begin
            preq_d_ff <= port_cfg_req;
            sreq_d_ff <= send_cfg_req;
            run_d_ff <= run_mode;
            flush_ff <= send_rise; // [R11]
            if (send_rise || stop_edge) pend_ff <= 1'b0; // [R11]
            else if (msg_req) pend_ff <= 1'b1;
            else if (st_ff == ST_IDLE) pend_ff <= 1'b0;
            rdata_ff <= reg_rd ? rd_mux : RD_NONE;
        end
    end

    // millisecond and bit-time dividers, restarted on each state change
    wire logic chg = nxt_st != st_ff;
    wire logic take = ready_ff && tx_valid;
    wire logic ms_tick = ms_div_ff == MS_CYC - 1;
    wire logic bit_tick = bit_div_ff == bit_cyc - 32'h0000_0001;
    wire logic bit_state = (st_ff == ST_GAP) || (st_ff == ST_BRK);
    wire logic cnt_tick = bit_state ? bit_tick : ms_tick;
    wire logic cts_to = st_ff == ST_CTS && !cts && cnt_ff == wait_ms;
    wire logic p_to = paused_ff && p_cnt_ff == wait_ms; // [R4]

    // transmit sequence: lead, cts, idle gap, break, data, trail
    always_comb begin
        nxt_st = st_ff;
        case (st_ff)
            ST_IDLE: if (pend_ff) nxt_st = hw_fc ? ST_LEAD : ST_GAP;
            ST_LEAD: if (cnt_ff == act_dly_ff.handshake_lead_delay)
                nxt_st = ST_CTS; // [R12]
            ST_CTS: begin // [R5]
                if (cts) nxt_st = ST_GAP;
                else if (cts_to) nxt_st = ST_IDLE;
            end
            ST_GAP: if (cnt_ff == act_gap_ff.pre_message_idle_bits)
                nxt_st = ST_BRK; // [R15]
            ST_BRK: if (cnt_ff == act_gap_ff.break_bits)
                nxt_st = ST_DATA; // [R14]
            ST_DATA: if (left_ff == 4'h0 && last_ff)
                nxt_st = hw_fc ? ST_TRAIL : ST_IDLE;
            ST_TRAIL: if (cnt_ff == act_dly_ff.handshake_trail_delay)
                nxt_st = ST_IDLE; // [R13]
            default: nxt_st = ST_IDLE;
        endcase
    end

    // state, dividers and delay counter
    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            st_ff <= ST_IDLE;
            ms_div_ff <= 32'h0000_0000;
            bit_div_ff <= 32'h0000_0000;
            cnt_ff <= 16'h0000;
        end else begin
            st_ff <= nxt_st;
            ms_div_ff <= (chg || ms_tick) ? 32'h0000_0000 :
                         ms_div_ff + 32'h0000_0001;
            bit_div_ff <= (chg || take || bit_tick) ? 32'h0000_0000 :
                          bit_div_ff + 32'h0000_0001;
            cnt_ff <= chg ? 16'h0000 : cnt_ff + {15'h0000, cnt_tick};
        end
    end

    // byte intake and serialiser
    wire logic rdy_ok = st_ff == ST_DATA && left_ff == 4'h0 &&
                        !paused_ff && !last_ff;
    wire logic [3:0] frame_len = 4'h1 +
        ((act_port_ff.char_length_select == LEN_7) ? 4'h7 : 4'h8) +
        ((act_port_ff.parity == PAR_NONE) ? 4'h0 : 4'h1) +
        ((act_port_ff.stop_bit_select == STOP_2) ? 4'h2 : 4'h1); // [R22]
    wire logic shift = st_ff == ST_DATA && left_ff != 4'h0 && bit_tick;
    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            ser_ff <= 12'hFFF;
            left_ff <= 4'h0;
            last_ff <= 1'b0;
            ready_ff <= 1'b0;
        end else begin
            ready_ff <= rdy_ok && !take;
            if (take) begin
                ser_ff <= make_frame(tx_data, act_port_ff); // [R21]
                left_ff <= frame_len;
            end else if (shift) begin
                ser_ff <= {1'b1, ser_ff[11:1]};
                left_ff <= left_ff - 4'h1;
            end
            if (st_ff == ST_IDLE) last_ff <= 1'b0;
            else if (take && tx_last) last_ff <= 1'b1;
        end
    end

    // line level, handshake output, busy and timeout pulse
    wire logic nxt_line = (st_ff == ST_BRK) ? 1'b0 : // [R23]
        (st_ff == ST_DATA && left_ff != 4'h0) ? ser_ff[0] : 1'b1;
    wire logic nxt_rts =
        (act_port_ff.flow_control_select == FLOW_HW_ON) || // [R1]
        (act_port_ff.flow_control_select == FLOW_HW_SW &&
         nxt_st != ST_IDLE); // [R13]
    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            line_ff <= 1'b1;
            rts_ff <= 1'b0;
            busy_ff <= 1'b0;
            to_ff <= 1'b0;
        end else begin
            line_ff <= nxt_line;
            rts_ff <= nxt_rts;
            busy_ff <= nxt_st != ST_IDLE;
            to_ff <= cts_to || p_to; // [R4] [R5]
        end
    end

    // pause and resume characters, honoured only with software flow
    wire logic pause_hit = sw_fc && rx_char_valid &&
                           rx_char == act_flow_ff.pause_char_code; // [R3]
    wire logic resume_hit = sw_fc && rx_char_valid &&
                            rx_char == act_flow_ff.resume_char_code; // [R2]
    always_ff @(posedge sys_clk or negedge rst_s_n) begin
        if (!rst_s_n) begin
            paused_ff <= 1'b0;
            p_cnt_ff <= 16'h0000;
        end else begin
            if (!sw_fc) paused_ff <= 1'b0;
            else if (pause_hit) paused_ff <= 1'b1;
            else if (resume_hit || p_to) paused_ff <= 1'b0; // [R4]
            p_cnt_ff <= (pause_hit || !paused_ff) ? 16'h0000 :
                        p_cnt_ff + {15'h0000, ms_tick};
        end
    end

    assign reg_rdata = rdata_ff;
    assign cfg_done = done_ff;
    assign cfg_error = error_ff;
    assign cfg_status = status_ff;
    assign tx_ready = ready_ff;
    assign tx_flush = flush_ff;
    assign tx_busy = busy_ff;
    assign tx_line = line_ff;
    assign rts = rts_ff;
    assign flow_timeout = to_ff;

    // result pulses
    done_error_excl_a: // [R6]
        assert property (!(done_ff && error_ff))
            else $error("done and error together");
    done_single_a: // [R6]
        assert property (done_ff |=> !done_ff)
            else $error("done longer than one cycle");
    done_status_a: // [R24]
        assert property (port_rise ##1 done_ff |-> status_ff == ST_OK)
            else $error("status not zero on success");
    bad_flow_a: // [R1]
        assert property (port_rise && port_code == ST_FLOW |=>
                         error_ff && status_ff == ST_FLOW)
            else $error("bad flow select not refused");
    reject_keep_a: // [R24]
        assert property (error_ff && !$past(stop_edge) |->
                         $stable(act_port_ff) && $stable(act_gap_ff))
            else $error("rejected setup changed settings");
    flush_clears_a: // [R11]
        assert property (send_rise |=> flush_ff && !pend_ff)
            else $error("queue not discarded");
    // line levels and handshake
    break_space_a: // [R23]
        assert property (st_ff == ST_BRK |=> !line_ff)
            else $error("break not at space");
    gap_mark_a: // [R15]
        assert property (st_ff == ST_GAP |=> line_ff)
            else $error("idle gap not at mark");
    lead_rts_a: // [R12]
        assert property (st_ff == ST_LEAD |=> rts_ff && line_ff)
            else $error("lead delay without rts or with data");
    cts_bound_a: // [R5]
        assert property (st_ff == ST_CTS |-> cnt_ff <= wait_ms)
            else $error("cts wait overran");
    pause_bound_a: // [R4]
        assert property (paused_ff |-> p_cnt_ff <= wait_ms)
            else $error("pause wait overran");
endmodule
`default_nettype wire

//--- sim/remote_dev.sv
// remote serial device answering the handshake output with cts
// assumes the port clock; quiet makes it a peer that never answers
`default_nettype none
module remote_dev (
    input wire logic sys_clk,
    input wire logic rts,
    input wire logic quiet,
    output logic cts
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] dly_ff = 3'h0;
    // cts trails rts by three cycles of turnaround
    always_ff @(posedge sys_clk) begin
        dly_ff <= {dly_ff[1:0], rts & ~quiet};
    end
    assign cts = dly_ff[2];
endmodule
`default_nettype wire

//--- sim/test_serial_port_tx_config.sv
// bench for the serial port settings and transmit framing block
// assumes remote_dev on cts; CLK_HZ cut so 1 ms is 1000 cycles
`default_nettype none
module test_serial_port_tx_config;
    import sp_cfg_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, quiet = 0;
    logic port_cfg_req = 0, send_cfg_req = 0, run_mode = 1, msg_req = 0;
    logic tx_valid = 0, cts, seen, cfg_done, cfg_error, tx_ready, tx_flush;
    logic tx_busy, tx_line, rts, flow_timeout;
    logic [7:0] reg_addr = 8'h00, rx_char = 8'h00;
    logic rx_char_valid = 0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_q, pw;
    logic [15:0] cfg_status, lfsr_q = 16'd4462;
    int n_fail = 0, cmp_count = 0, run = 0;
    localparam logic [31:0] BP [9] = '{32'h111116, 32'h011110, 32'h01111C,
        32'h011166, 32'h011316, 32'h010116, 32'h051116, 32'h021116,
        32'h021116};
    localparam logic [31:0] BF [9] = '{DEF_FLOW, DEF_FLOW, DEF_FLOW,
        DEF_FLOW, DEF_FLOW, DEF_FLOW, DEF_FLOW, 32'h1311, 32'h07D01111};
    localparam logic [15:0] BC [9] = '{16'h80A0, 16'h80A1, 16'h80A1,
        16'h80A2, 16'h80A3, 16'h80A4, 16'h80A5, 16'h80A6, 16'h80A7};
    always #2 sys_clk = ~sys_clk;
    serial_port_tx_config #(.CLK_HZ(1000000)) DUT (.sys_clk(sys_clk),
        .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .port_cfg_req(port_cfg_req), .send_cfg_req(send_cfg_req),
        .run_mode(run_mode), .cfg_done(cfg_done), .cfg_error(cfg_error),
        .cfg_status(cfg_status), .msg_req(msg_req), .tx_valid(tx_valid),
        .tx_data(8'hFF), .tx_last(1'b1), .tx_ready(tx_ready),
        .tx_flush(tx_flush), .tx_busy(tx_busy), .tx_line(tx_line),
        .rts(rts), .cts(cts), .rx_char_valid(rx_char_valid),
        .rx_char(rx_char),
        .flow_timeout(flow_timeout));
    remote_dev peer (.sys_clk(sys_clk), .rts(rts), .quiet(quiet), .cts(cts));
    // shift register source of stimulus values
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge sys_clk);
        reg_wr <= 0;
        @(posedge sys_clk);
    endtask
    // one received character from the remote device
    task automatic rxc(input logic [7:0] c);
        rx_char <= c;
        rx_char_valid <= 1;
        @(posedge sys_clk);
        rx_char_valid <= 0;
    endtask
    // wait for the timeout pulse, bounded
    task automatic wait_to();
        seen = 0;
        for (int i = 0; i < 1200 && !seen; i++)
            @(posedge sys_clk) #1 seen = flow_timeout;
    endtask
    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge sys_clk);
        reg_rd <= 0;
        #1 rd_q = reg_rdata;
        @(posedge sys_clk);
    endtask
    // one rising request, then a low cycle before the next
    task automatic req(input logic snd, input logic [15:0] code);
        if (snd) send_cfg_req <= 1;
        else port_cfg_req <= 1;
        seen = 0;
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk);
            #1 seen = seen | tx_flush;
            if (cfg_done | cfg_error) break;
        end
        chk(cfg_error, code != 16'h0);
        chk(cfg_done, code == 16'h0);
        chk(cfg_status, code);
        @(posedge sys_clk);
        #1 seen = seen | tx_flush;
        send_cfg_req <= 0;
        port_cfg_req <= 0;
        @(posedge sys_clk);
        if (snd) chk(seen, 1);
    endtask
    task automatic cfg(input logic [31:0] p, f, input logic [15:0] c);
        wr(A_PORT, p);
        wr(A_FLOW, f);
        req(0, c);
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // main sequence of scenarios
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1;
        repeat (3) @(posedge sys_clk);
        rd(A_ACTF);
        chk(rd_q, DEF_FLOW);
        rd(8'h40);
        chk(rd_q, RD_NONE);
        for (int i = 0; i < 9; i++) cfg(BP[i], BF[i], BC[i]);
        rd(A_ACTP);
        chk(rd_q, {8'h0, DEF_PORT});
        for (int m = 1; m < 5; m++) begin
            lfsr_q = lfsr(lfsr_q);
            pw = {12'h0, 4'(m), 4'(lfsr_q[0]) + 4'h1, 4'(lfsr_q[1]) + 4'h1,
                4'(lfsr_q[4:2] % 5) + 4'h1, 4'h1};
            cfg(pw, 32'h00011311, 16'h0);
            rd(A_ACTP);
            chk(rd_q, pw);
            chk(rts, m == 3);
        end
        wr(A_TXCTL, 32'h1);
        req(1, ST_TXINT);
        wr(A_TXCTL, 32'h0);
        wr(A_GAP, 32'h0000FFFF);
        req(1, ST_BRKLEN);
        wr(A_GAP, 32'hFFFF0000);
        req(1, ST_IDLELEN);
        wr(A_GAP, 32'h0);
        wr(A_DLY, 32'h0);
        req(1, 16'h0);
        quiet <= 1;
        msg_req <= 1;
        @(posedge sys_clk);
        msg_req <= 0;
        wait_to();
        chk(seen, 1);
        quiet <= 0;
        run_mode <= 0;
        @(posedge sys_clk);
        run_mode <= 1;
        rd(A_ACTP);
        chk(rd_q, {8'h0, DEF_PORT});
        cfg(32'h01111B, DEF_FLOW, 16'h0);
        wr(A_GAP, 32'h2);
        req(1, 16'h0);
        tx_valid <= 1;
        msg_req <= 1;
        @(posedge sys_clk);
        msg_req <= 0;
        seen = 0;
        for (int i = 0; i < 400; i++) begin
            @(posedge sys_clk);
            if (seen) tx_valid <= 0;
            #1 seen = tx_valid & tx_ready;
            run += int'(!tx_line);
            if (!tx_busy && !tx_valid) break;
        end
        chk(run >= 24 && run <= 27, 1);
        chk(tx_line, 1);
        cfg(32'h02111B, 32'h00011311, 16'h0);
        rxc(8'h13);
        rd(A_STAT);
        chk(rd_q[17], 1);
        rxc(8'h11);
        rd(A_STAT);
        chk(rd_q[17], 0);
        rxc(8'h13);
        wait_to();
        chk(seen, 1);
        rd(A_STAT);
        chk(rd_q[17], 0);
        results();
    end
    // hang guard
    initial begin
        #200000;
        n_fail++;
        results();
    end
endmodule
`default_nettype wire
